//--- src/mrad_top.sv
// Region attribute decoder between core fetch/data ports and the memory bus
// Contract
// - word, halfword and byte data accesses supported
// - data lanes are little-endian
// - fixed map decodes full 4GB space
// - Normal accesses may be reordered or speculative
// - Device keeps order with Device/Strongly-ordered
// - Strongly-ordered keeps order with everything
// - Device writes bufferable, Strongly-ordered never
// - fetch from execute-never region raises hard fault
// - 0x00000000 is executable Normal code
// - 0x20000000 is executable Normal SRAM
// - 0x60000000 is executable Normal external RAM
// - peripheral, external device, vendor are Device, no-execute
// - 0xE0000000 private region Strongly-ordered, no-execute
// - private region accepts word accesses only
// - Device/Strongly-ordered pairs observed in program order
// - pairs with Normal have no ordering promise
`timescale 1ns/1ps
`default_nettype none
`include "mrad_consts.svh"
module mrad_top
  import mrad_pkg::*;
#(
  parameter int WBUF_DEPTH = `MRAD_WBUF_DEPTH
) (
  input wire logic clock, // 20 MHz clock
  input wire logic rst_b, // Synchronous reset, active low
  // Instruction fetch side
  input wire logic if_req, // Fetch request
  input wire logic [31:0] if_addr, // Fetch address
  output logic if_gnt, // Fetch accepted (registered pulse)
  output logic if_fault, // Hard fault on execute-never fetch
  // Core data side
  input wire logic d_req, // Data request
  input wire logic d_we, // Write
  input wire logic [1:0] d_size, // 0 byte, 1 half, 2 word
  input wire logic [31:0] d_addr, // Address
  input wire logic [31:0] d_wdata, // Right aligned write data
  output logic d_ready, // Decoder can take a data request
  output logic d_done, // Access completed pulse
  output logic d_err, // Access refused pulse
  output logic [31:0] d_rdata, // Right aligned read data
  // Memory bus side
  output logic m_req, // Bus request level
  output logic m_we, // Bus write
  output logic [31:0] m_addr, // Bus address
  output logic [31:0] m_wdata, // Lane placed write data
  output logic [3:0] m_strb, // Byte lane strobes
  output logic m_fetch, // Request is instruction fetch
  input wire logic m_ack, // Bus slave done
  input wire logic [31:0] m_rdata // Bus read word
);
  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MRAD_ST_IDLE = 2'h0,
    MRAD_ST_BUS = 2'h1,
    MRAD_ST_DONE = 2'h2
  } mrad_state_t;

  typedef struct packed {
    logic [WBUF_DEPTH-1:0][31:0] wb_addr;
    logic [WBUF_DEPTH-1:0][31:0] wb_data;
    logic [WBUF_DEPTH-1:0][3:0] wb_strb;
    logic [$clog2(WBUF_DEPTH+1)-1:0] wb_cnt;
    mrad_state_t st;
    logic from_wb;
    logic is_fetch;
    logic if_gnt;
    logic if_fault;
    logic d_ready;
    logic d_done;
    logic d_err;
    logic [31:0] d_rdata;
    logic [1:0] size;
    logic [1:0] addr_lo;
    logic m_req;
    logic m_we;
    logic [31:0] m_addr;
    logic [31:0] m_wdata;
    logic [3:0] m_strb;
  } mrad_reg_t;

  mrad_reg_t s_q;
  mrad_reg_t s_d;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  mrad_region_t d_region;
  mrad_mtype_t d_mtype;
  mrad_mtype_t i_mtype;
  logic d_xn;
  logic i_xn;
  logic [31:0] lane_wdata;
  logic [3:0] lane_strb;
  logic [31:0] lane_rdata;

  // Data address decode over the whole space
  mrad_region_map u_dmap (
    .addr(d_addr),
    .region(d_region),
    .mtype(d_mtype),
    .execute_never_attr(d_xn)
  );

  // Fetch address decode
  mrad_region_map u_imap (
    .addr(if_addr),
    .region(),
    .mtype(i_mtype),
    .execute_never_attr(i_xn)
  );

  // Byte lanes
  mrad_lane_steer u_lane (
    .size(d_size),
    .addr_lo(d_addr[1:0]),
    .wdata_in(d_wdata),
    .rdata_in(m_rdata),
    .wdata_out(lane_wdata),
    .strb_out(lane_strb),
    .rdata_out(lane_rdata)
  );

  // Pick read lanes with the size captured at issue
  function automatic logic [31:0] mrad_pick(input logic [1:0] sz, input logic [1:0] lo, input logic [31:0] w);
    logic [31:0] r;
    r = w >> {lo, 3'h0};
    case (sz)
      `MRAD_SIZE_BYTE: mrad_pick = {24'h0, r[7:0]};
      `MRAD_SIZE_HALF: mrad_pick = {16'h0, r[15:0]};
      default: mrad_pick = r;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic d_bad;
  logic wb_full;
  logic can_post;
  logic must_drain;
  logic unused_lane;

  always_comb begin
    s_d = s_q;
    s_d.if_gnt = 1'b0;
    s_d.if_fault = 1'b0;
    s_d.d_done = 1'b0;
    s_d.d_err = 1'b0;
    unused_lane = |lane_rdata;
    // Private region takes words only
    d_bad = (d_region == MRAD_RGN_PRIV) && (d_size != `MRAD_SIZE_WORD);
    wb_full = (s_q.wb_cnt == WBUF_DEPTH[$bits(s_q.wb_cnt)-1:0]);
    // Device writes may be posted
    can_post = d_we && (d_mtype == MRAD_DEVICE) && !wb_full;
    // Strongly-ordered or Device accesses, and any read, wait for posted writes
    must_drain = (s_q.wb_cnt != '0) && (d_mtype != MRAD_NORMAL || !d_we);
    case (s_q.st)
      MRAD_ST_IDLE: begin
        s_d.d_ready = 1'b1;
        // One grant per fetch request; the core drops if_req on the grant edge
        if (if_req && !s_q.if_gnt && i_xn) begin
          // No bus access for a forbidden fetch
          s_d.if_fault = 1'b1;
          s_d.if_gnt = 1'b1;
        end else if (if_req && !s_q.if_gnt && !i_xn && (s_q.wb_cnt == '0 || i_mtype == MRAD_NORMAL)) begin
          // Normal fetch may overtake posted writes
          s_d.st = MRAD_ST_BUS;
          s_d.is_fetch = 1'b1;
          s_d.from_wb = 1'b0;
          s_d.m_req = 1'b1;
          s_d.m_we = 1'b0;
          s_d.m_addr = if_addr;
          s_d.m_strb = 4'hf;
          s_d.d_ready = 1'b0;
          s_d.if_gnt = 1'b1;
        end else if (d_req && s_q.d_ready && d_bad) begin
          s_d.d_err = 1'b1;
          s_d.d_ready = 1'b0; // Request still high on the answer edge must not be taken again
        end else if (d_req && s_q.d_ready && can_post && !must_drain) begin
          // Posted Device write, completes at once
          s_d.wb_addr[s_q.wb_cnt] = d_addr;
          s_d.wb_data[s_q.wb_cnt] = lane_wdata;
          s_d.wb_strb[s_q.wb_cnt] = lane_strb;
          s_d.wb_cnt = s_q.wb_cnt + 1'b1;
          s_d.d_done = 1'b1;
          s_d.d_ready = 1'b0; // Avoid posting the same write twice
        end else if (d_req && s_q.d_ready && !must_drain && !(d_we && d_mtype == MRAD_DEVICE)) begin
          // Direct access; Strongly-ordered writes never buffered
          s_d.st = MRAD_ST_BUS;
          s_d.is_fetch = 1'b0;
          s_d.from_wb = 1'b0;
          s_d.m_req = 1'b1;
          s_d.m_we = d_we;
          s_d.m_addr = d_addr;
          s_d.m_wdata = lane_wdata;
          s_d.m_strb = lane_strb;
          s_d.size = d_size;
          s_d.addr_lo = d_addr[1:0];
          s_d.d_ready = 1'b0;
        end else if (s_q.wb_cnt != '0) begin
          // Drain oldest posted write first, in program order
          s_d.st = MRAD_ST_BUS;
          s_d.from_wb = 1'b1;
          s_d.d_ready = 1'b0;
          s_d.is_fetch = 1'b0;
          s_d.m_req = 1'b1;
          s_d.m_we = 1'b1;
          s_d.m_addr = s_q.wb_addr[0];
          s_d.m_wdata = s_q.wb_data[0];
          s_d.m_strb = s_q.wb_strb[0];
        end
      end
      MRAD_ST_BUS: begin
        if (m_ack) begin
          s_d.m_req = 1'b0;
          s_d.st = MRAD_ST_DONE;
          if (s_q.from_wb) begin
            // Shift the queue down one slot
            for (int i = 0; i < WBUF_DEPTH - 1; i++) begin
              s_d.wb_addr[i] = s_q.wb_addr[i+1];
              s_d.wb_data[i] = s_q.wb_data[i+1];
              s_d.wb_strb[i] = s_q.wb_strb[i+1];
            end
            s_d.wb_cnt = s_q.wb_cnt - 1'b1;
          end else if (!s_q.is_fetch) begin
            s_d.d_done = 1'b1;
            if (!s_q.m_we) begin
              s_d.d_rdata = mrad_pick(s_q.size, s_q.addr_lo, m_rdata);
            end
          end
        end
      end
      MRAD_ST_DONE: begin
        s_d.st = MRAD_ST_IDLE;
        s_d.d_ready = 1'b1;
      end
      default: s_d.st = MRAD_ST_IDLE;
    endcase
    if (!rst_b) begin
      s_d = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    s_q <= s_d;
  end

  // Outputs come straight from the state register
  assign if_gnt = s_q.if_gnt;
  assign if_fault = s_q.if_fault;
  assign d_ready = s_q.d_ready;
  assign d_done = s_q.d_done;
  assign d_err = s_q.d_err;
  assign d_rdata = s_q.d_rdata;
  assign m_req = s_q.m_req;
  assign m_we = s_q.m_we;
  assign m_addr = s_q.m_addr;
  assign m_wdata = s_q.m_wdata;
  assign m_strb = s_q.m_strb;
  assign m_fetch = s_q.is_fetch;
endmodule
`default_nettype wire

//--- src/mrad_consts.svh
// Address map bounds, access size codes and write buffer depth of the region decoder
`ifndef MRAD_CONSTS_SVH
`define MRAD_CONSTS_SVH
`define MRAD_CODE_BASE 32'h0000_0000
`define MRAD_SRAM_BASE 32'h2000_0000
`define MRAD_PERI_BASE 32'h4000_0000
`define MRAD_XRAM_BASE 32'h6000_0000
`define MRAD_XDEV_BASE 32'ha000_0000
`define MRAD_PRIV_BASE 32'he000_0000
`define MRAD_VEND_BASE 32'he010_0000
`define MRAD_SIZE_BYTE 2'h0
`define MRAD_SIZE_HALF 2'h1
`define MRAD_SIZE_WORD 2'h2
`define MRAD_WBUF_DEPTH 4
`endif

//--- src/mrad_pkg.sv
// Types shared by the region decoder modules
package mrad_pkg;
  typedef enum logic [1:0] {
    MRAD_NORMAL = 2'h0,
    MRAD_DEVICE = 2'h1,
    MRAD_STRONG = 2'h2
  } mrad_mtype_t;
  typedef enum logic [2:0] {
    MRAD_RGN_CODE = 3'h0,
    MRAD_RGN_SRAM = 3'h1,
    MRAD_RGN_PERI = 3'h2,
    MRAD_RGN_XRAM = 3'h3,
    MRAD_RGN_XDEV = 3'h4,
    MRAD_RGN_PRIV = 3'h5,
    MRAD_RGN_VEND = 3'h6
  } mrad_region_t;
endpackage

//--- src/mrad_region_map.sv
// Combinational address to region, memory type and execute-never lookup
`timescale 1ns/1ps
`default_nettype none
`include "mrad_consts.svh"
module mrad_region_map
  import mrad_pkg::*;
(
  input wire logic [31:0] addr, // Address to decode
  output mrad_region_t region, // Region index
  output mrad_mtype_t mtype, // Memory type
  output logic execute_never_attr // Instruction fetch forbidden
);
  // Ranges checked from the top down
  always_comb begin
    if (addr >= `MRAD_VEND_BASE) begin
      region = MRAD_RGN_VEND;
    end else if (addr >= `MRAD_PRIV_BASE) begin
      region = MRAD_RGN_PRIV;
    end else if (addr >= `MRAD_XDEV_BASE) begin
      region = MRAD_RGN_XDEV;
    end else if (addr >= `MRAD_XRAM_BASE) begin
      region = MRAD_RGN_XRAM;
    end else if (addr >= `MRAD_PERI_BASE) begin
      region = MRAD_RGN_PERI;
    end else if (addr >= `MRAD_SRAM_BASE) begin
      region = MRAD_RGN_SRAM;
    end else begin
      region = MRAD_RGN_CODE;
    end
  end
  // Attributes per region
  always_comb begin
    case (region)
      MRAD_RGN_CODE, MRAD_RGN_SRAM, MRAD_RGN_XRAM: begin
        mtype = MRAD_NORMAL;
        execute_never_attr = 1'b0;
      end
      MRAD_RGN_PRIV: begin
        mtype = MRAD_STRONG;
        execute_never_attr = 1'b1;
      end
      default: begin
        mtype = MRAD_DEVICE;
        execute_never_attr = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

//--- src/mrad_lane_steer.sv
// Little-endian byte lane steering for write data and read data
`timescale 1ns/1ps
`default_nettype none
`include "mrad_consts.svh"
module mrad_lane_steer (
  input wire logic [1:0] size, // Access size code
  input wire logic [1:0] addr_lo, // Low address bits
  input wire logic [31:0] wdata_in, // Core write data, right aligned
  input wire logic [31:0] rdata_in, // Bus read word
  output logic [31:0] wdata_out, // Write data on lanes
  output logic [3:0] strb_out, // Byte lane strobes
  output logic [31:0] rdata_out // Read data, right aligned
);
  logic [4:0] sh;
  // Least significant byte sits at the lowest byte address
  always_comb begin
    sh = {addr_lo, 3'h0};
    wdata_out = wdata_in << sh;
    rdata_out = rdata_in >> sh;
    case (size)
      `MRAD_SIZE_BYTE: begin
        strb_out = 4'h1 << addr_lo;
        rdata_out = {24'h0, rdata_out[7:0]};
      end
      `MRAD_SIZE_HALF: begin
        strb_out = 4'h3 << addr_lo;
        rdata_out = {16'h0, rdata_out[15:0]};
      end
      default: strb_out = 4'hf;
    endcase
  end
endmodule
`default_nettype wire

//--- bench/mrad_checker.sv
// Assertions on the region decoder top ports
`timescale 1ns/1ps
`default_nettype none
module mrad_checker (
  input wire logic clock, // Clock
  input wire logic rst_b, // Reset
  input wire logic if_gnt, // Fetch taken
  input wire logic if_fault, // Fetch fault
  input wire logic d_done, // Data done
  input wire logic d_err, // Refused
  input wire logic [31:0] d_rdata, // Read data
  input wire logic m_req, // Bus request
  input wire logic m_we, // Bus write
  input wire logic [31:0] m_addr, // Bus address
  input wire logic [3:0] m_strb, // Strobes
  input wire logic m_fetch, // Bus fetch
  input wire logic m_ack // Bus done
);
  logic xn_a, prv_a;
  // ----
  // Region of the bus address
  // ----
  assign xn_a = (m_addr >= 32'h4000_0000 && m_addr < 32'h6000_0000) || m_addr >= 32'ha000_0000;
  assign prv_a = m_addr >= 32'he000_0000 && m_addr < 32'he010_0000;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // ----
  // Checks
  // ----
  a_fault_has_gnt: assert property (if_fault |-> if_gnt)
    else $error("fault without grant");
  a_fetch_exec: assert property (m_req && m_fetch |-> !xn_a)
    else $error("fetch to no-execute region");
  a_priv_word: assert property (m_req && m_we && prv_a |-> m_strb == 4'hf)
    else $error("narrow write to private region");
  a_bus_hold: assert property (m_req && !m_ack |=> m_req && $stable(m_addr) && $stable(m_strb))
    else $error("bus request moved before ack");
  a_done_ack: assert property (m_req && m_ack && !m_fetch && !(m_we && xn_a && !prv_a) |=> d_done)
    else $error("no completion after ack");
  a_idle_gap: assert property (m_req && m_ack |=> !m_req)
    else $error("no idle cycle after access");
  a_rdata_done: assert property (!$stable(d_rdata) |-> d_done)
    else $error("read data moved alone");
  a_strb_legal: assert property (m_req && m_we |-> m_strb inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
    else $error("illegal lane strobes");
  a_err_alone: assert property (d_err |-> !d_done)
    else $error("refusal with completion");
  c_fault: cover property (if_fault);
  c_refused: cover property (d_err);
  c_priv_write: cover property (m_req && m_ack && m_we && prv_a);
endmodule
`default_nettype wire

//--- bench/mrad_bus_slave.sv
// Behavioural memory bus slave, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module mrad_bus_slave (
  input wire logic clock, // Clock
  input wire logic rst_b, // Reset
  input wire logic slow, // Add wait cycles
  input wire logic m_req, // Bus request
  input wire logic m_we, // Bus write
  input wire logic [31:0] m_addr, // Bus address
  input wire logic [31:0] m_wdata, // Lane data
  input wire logic [3:0] m_strb, // Strobes
  output logic m_ack, // Done pulse
  output logic [31:0] m_rdata // Read word
);
  logic [31:0] mem [logic [29:0]];
  logic [31:0] w;
  int wait_n;
  // Answer after zero or three wait cycles; data never lingers
  always @(posedge clock) begin
    m_ack <= 1'b0;
    m_rdata <= ~m_rdata;
    if (!rst_b) begin
      wait_n <= 0;
      m_rdata <= 32'h0;
    end else if (m_req && !m_ack) begin
      if (wait_n != 0) begin
        wait_n <= wait_n - 1;
      end else begin
        m_ack <= 1'b1;
        wait_n <= slow ? 3 : 0;
        w = mem.exists(m_addr[31:2]) ? mem[m_addr[31:2]] : ~m_addr;
        for (int i = 0; i < 4; i++) begin
          if (m_we && m_strb[i]) w[8*i+:8] = m_wdata[8*i+:8];
        end
        if (m_we) mem[m_addr[31:2]] = w;
        m_rdata <= w;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/mrad_tb_top.sv
// Self-checking bench for the region attribute decoder
`timescale 1ns/1ps
`default_nettype none
module mrad_tb_top;
  logic clock = 1'b0, rst_b = 1'b0, if_req = 1'b0, d_req = 1'b0, d_we = 1'b0, slow = 1'b0;
  logic [1:0] d_size = 2'h2;
  logic [31:0] if_addr = 32'h0, d_addr = 32'h0, d_wdata = 32'h0;
  logic if_gnt, if_fault, d_ready, d_done, d_err, m_req, m_we, m_fetch, m_ack;
  logic [3:0] m_strb;
  logic [31:0] d_rdata, m_addr, m_wdata, m_rdata;
  int fails = 0, samples_checked = 0, seed = 1803;
  logic [31:0] fa [12] = '{32'h0, 32'h1fff_fffc, 32'h2000_0000, 32'h4000_0000, 32'h5fff_fffc, 32'h6000_0000,
    32'h9fff_fffc, 32'ha000_0000, 32'he000_0000, 32'he00f_fffc, 32'he010_0000, 32'hffff_fffc};
  logic [31:0] base [7] = '{32'h0, 32'h2000_0000, 32'h4000_0000, 32'h6000_0000, 32'ha000_0000,
    32'he000_0000, 32'he010_0000};
  // Clock of 50 ns period
  always #25 clock = ~clock;
  mrad_top u_mrad_top (.clock, .rst_b, .if_req, .if_addr, .if_gnt, .if_fault, .d_req, .d_we, .d_size, .d_addr,
    .d_wdata, .d_ready, .d_done, .d_err, .d_rdata, .m_req, .m_we, .m_addr, .m_wdata, .m_strb, .m_fetch,
    .m_ack, .m_rdata);
  mrad_bus_slave u_mrad_bus_slave (.clock, .rst_b, .slow, .m_req, .m_we, .m_addr, .m_wdata, .m_strb,
    .m_ack, .m_rdata);
  // ----
  // Helpers
  // ----
  function automatic logic exp_xn(input logic [31:0] a);
    return (a >= 32'h4000_0000 && a < 32'h6000_0000) || a >= 32'ha000_0000;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Random size and aligned lane; private region stays word only
  task automatic pick(input logic prv, output logic [1:0] sz, output int ln, output logic [31:0] mk);
    logic [31:0] v;
    v = $random(seed);
    sz = (prv || v[1:0] == 2'h3) ? 2'h2 : v[1:0];
    ln = sz == 2'h0 ? int'(v[3:2]) : sz == 2'h1 ? 2 * int'(v[2]) : 0;
    mk = (sz == 2'h0 ? 32'hff : sz == 2'h1 ? 32'hffff : 32'hffff_ffff) << (8 * ln);
  endtask
  // One data access, request held until completion or refusal
  task automatic dacc(input logic we, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    int n;
    @(posedge clock);
    d_req <= 1'b1;
    d_we <= we;
    d_size <= sz;
    d_addr <= a;
    d_wdata <= wd;
    @(posedge clock);
    for (n = 0; n < 300 && d_done !== 1'b1 && d_err !== 1'b1; n++) @(posedge clock);
    if (n == 300) begin
      fails++;
      tally_and_finish();
    end
    rd = d_rdata;
    er = d_err;
    d_req <= 1'b0;
  endtask
  // One instruction fetch, held until granted
  task automatic fetch(input logic [31:0] a, output logic flt);
    int n;
    @(posedge clock);
    if_req <= 1'b1;
    if_addr <= a;
    @(posedge clock);
    for (n = 0; n < 300 && if_gnt !== 1'b1; n++) @(posedge clock);
    if (n == 300) begin
      fails++;
      tally_and_finish();
    end
    flt = if_fault;
    if_req <= 1'b0;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] a, v, ex, rd, mk;
    logic [1:0] sz;
    logic er, flt;
    int r, ln;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    foreach (fa[i]) begin
      fetch(fa[i], flt);
      chk("fault", {31'h0, flt}, {31'h0, exp_xn(fa[i])});
    end
    for (int s = 0; s < 4; s++) begin
      dacc(s[1], {1'b0, s[0]}, 32'he000_e010, 32'h0, rd, er);
      chk("priv_refuse", {31'h0, er}, 32'h1);
    end
    // Back-to-back posted writes against a slow slave, then read back
    slow <= 1'b1;
    for (int k = 0; k < 6; k++) dacc(1'b1, 2'h2, 32'h4000_0200 + 32'(4 * k), 32'h1111_1111 * 32'(k), rd, er);
    for (int k = 0; k < 6; k++) begin
      dacc(1'b0, 2'h2, 32'h4000_0200 + 32'(4 * k), 32'h0, rd, er);
      chk("posted", rd, 32'h1111_1111 * 32'(k));
    end
    // Random mix of regions, sizes and lanes with fetches between
    for (int k = 0; k < 40; k++) begin
      r = {$random(seed)} % 7;
      a = base[r] + 32'h100 + 32'(4 * k);
      ex = $random(seed);
      slow <= ex[0];
      dacc(1'b1, 2'h2, a, ex, rd, er);
      chk("w_err", {31'h0, er}, 32'h0);
      pick(r == 5, sz, ln, mk);
      v = $random(seed) & (mk >> (8 * ln));
      dacc(1'b1, sz, a + 32'(ln), v, rd, er);
      ex = (ex & ~mk) | ((v << (8 * ln)) & mk);
      fetch(a, flt);
      chk("r_fault", {31'h0, flt}, {31'h0, exp_xn(a)});
      dacc(1'b0, 2'h2, a, 32'h0, rd, er);
      chk("word", rd, ex);
      pick(r == 5, sz, ln, mk);
      dacc(1'b0, sz, a + 32'(ln), 32'h0, rd, er);
      chk("part", rd, (ex & mk) >> (8 * ln));
    end
    tally_and_finish();
  end
endmodule
bind mrad_top mrad_checker u_mrad_checker (.clock, .rst_b, .if_gnt, .if_fault, .d_done, .d_err, .d_rdata,
  .m_req, .m_we, .m_addr, .m_strb, .m_fetch, .m_ack);
`default_nettype wire
